// ==== shared/ssr_consts.vh ====
/*
 * offsets, field positions and reset values of the status and result register bank.
 * assumes byte-wide register addressing by an upstream serial bus slave.
 */
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH

// ********************************
// register offsets
// ********************************
`define SSR_PART_NUMBER_OFS    8'h92
`define SSR_EVENT_FLAGS_OFS    8'h93
`define SSR_CLEAR_LOW_OFS      8'h94
`define SSR_CLEAR_HIGH_OFS     8'h95
`define SSR_RED_LOW_OFS        8'h96
`define SSR_RED_HIGH_OFS       8'h97
`define SSR_GREEN_LOW_OFS      8'h98
`define SSR_GREEN_HIGH_OFS     8'h99
`define SSR_BLUE_LOW_OFS       8'h9a
`define SSR_BLUE_HIGH_OFS      8'h9b
`define SSR_PROX_UPPER_OFS     8'h9c
`define SSR_MISC_CONFIG_OFS    8'hab

// ********************************
// field positions
// ********************************
`define SSR_BIT_ALS_SAT        7
`define SSR_BIT_PROX_SAT       6
`define SSR_BIT_PROX_INT       5
`define SSR_BIT_ALS_INT        4
`define SSR_BIT_CAL_INT        3
`define SSR_BIT_UNUSED         2
`define SSR_BIT_SAT_REFL       1
`define SSR_BIT_SAT_AMB        0
`define SSR_BIT_READ_CLEAR     7

// ********************************
// reset values
// ********************************
`define SSR_FLAGS_RST          8'h00
`define SSR_RESULT_RST         16'h0000
`define SSR_PROX_RST           8'h00
`define SSR_MISC_CONFIG_RST    8'h00

`endif

// ==== src/ssr_status_result_regs.v ====
/*
 * status flag and measurement result register bank of a colour/light/proximity sensor.
 * assumes a serial bus slave delivers one-cycle byte read and write strobes with an
 * 8-bit register address, and that measurement engines give one-cycle event pulses.
 */
// Functional notes
// - als saturation sets bit 7, sticky
// - proximity saturation sets bit 6, sticky
// - bit 5 shows proximity threshold interrupt
// - bit 4 shows als threshold interrupt
// - bit 3 calibration done, write-one clears
// - bit 1 reflective cause, cleared with bit 6
// - bit 0 ambient cause, cleared with bit 6
// - write one clears flag, zero keeps
// - status read clears only when enabled
// - clear-on-read bit 7 at 0xab, reset 0
// - clear result at 0x94/0x95, reset zero
// - calibration mode puts calibration result in clear
// - red result at 0x96/0x97, reset zero
// - green result at 0x98/0x99, reset zero
// - blue result at 0x9a/0x9b, reset zero
// - proximity register holds converter bits 9:2
// - als interrupt from clear channel only
`timescale 1ns/100ps
`include "ssr_consts.vh"

module ssr_status_result_regs #(
  parameter [5:0] PART_ID = 6'h15   // arbitrary value
) (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_rd,
  input  wire        als_sat_evt,
  input  wire        prox_sat_refl_evt,
  input  wire        prox_sat_amb_evt,
  input  wire        prox_int_evt,
  input  wire        clear_int_evt,
  input  wire        cal_done_evt,
  input  wire        als_done,
  input  wire [15:0] clear_meas,
  input  wire [15:0] red_meas,
  input  wire [15:0] green_meas,
  input  wire [15:0] blue_meas,
  input  wire        cal_mode,
  input  wire        cal_done,
  input  wire [15:0] cal_result,
  input  wire        prox_done,
  input  wire [9:0]  prox_meas,
  output reg  [7:0]  reg_rdata_q,
  output reg  [7:0]  flags_q,
  output reg         read_clear_q
);

  // ********************************
  // clear terms
  // ********************************
  wire       flags_wr  = reg_wr && (reg_addr == `SSR_EVENT_FLAGS_OFS);
  wire       flags_rd  = reg_rd && (reg_addr == `SSR_EVENT_FLAGS_OFS);
  wire       rd_clear  = flags_rd && read_clear_q;
  wire [7:0] wr_clear  = flags_wr ? reg_wdata : 8'h00;
  wire       sat_clr   = wr_clear[`SSR_BIT_PROX_SAT];
  reg  [7:0] set_v;
  reg  [7:0] clr_v;
  reg  [7:0] flags_d;

  reg  [15:0] clear_q;
  reg  [15:0] red_q;
  reg  [15:0] green_q;
  reg  [15:0] blue_q;
  reg  [7:0]  prox_q;
  reg  [7:0]  rdata_d;

  // ********************************
  // event flags
  // ********************************
  always @* begin
    set_v = 8'h00;
    set_v[`SSR_BIT_ALS_SAT]  = als_sat_evt;
    set_v[`SSR_BIT_PROX_SAT] = prox_sat_refl_evt | prox_sat_amb_evt;
    set_v[`SSR_BIT_PROX_INT] = prox_int_evt;
    set_v[`SSR_BIT_ALS_INT]  = clear_int_evt;
    set_v[`SSR_BIT_CAL_INT]  = cal_done_evt;
    set_v[`SSR_BIT_SAT_REFL] = prox_sat_refl_evt;
    set_v[`SSR_BIT_SAT_AMB]  = prox_sat_amb_evt;
    clr_v = wr_clear | {8{rd_clear}};
    clr_v[`SSR_BIT_SAT_REFL] = clr_v[`SSR_BIT_SAT_REFL] | sat_clr;
    clr_v[`SSR_BIT_SAT_AMB]  = clr_v[`SSR_BIT_SAT_AMB] | sat_clr;
    // set beats clear so an event in the clearing cycle survives
    flags_d = (flags_q & ~clr_v) | set_v;
    flags_d[`SSR_BIT_UNUSED] = 1'b0;
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_q      <= `SSR_FLAGS_RST;
      read_clear_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      if (reg_wr && (reg_addr == `SSR_MISC_CONFIG_OFS)) begin
        read_clear_q <= reg_wdata[`SSR_BIT_READ_CLEAR];
      end
    end
  end

  // ********************************
  // results
  // ********************************
  // results latch on engine completion so a byte pair read stays coherent
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      clear_q <= `SSR_RESULT_RST;
      red_q   <= `SSR_RESULT_RST;
      green_q <= `SSR_RESULT_RST;
      blue_q  <= `SSR_RESULT_RST;
      prox_q  <= `SSR_PROX_RST;
    end else begin
      if (cal_mode) begin
        if (cal_done) begin
          clear_q <= cal_result;
        end
      end else if (als_done) begin
        clear_q <= clear_meas;
      end
      if (als_done) begin
        red_q   <= red_meas;
        green_q <= green_meas;
        blue_q  <= blue_meas;
      end
      if (prox_done) begin
        prox_q <= prox_meas[9:2];
      end
    end
  end

  // ********************************
  // read port
  // ********************************
  always @* begin
    case (reg_addr)
      `SSR_PART_NUMBER_OFS: rdata_d = {PART_ID, 2'b00};
      `SSR_EVENT_FLAGS_OFS: rdata_d = flags_q;
      `SSR_CLEAR_LOW_OFS:   rdata_d = clear_q[7:0];
      `SSR_CLEAR_HIGH_OFS:  rdata_d = clear_q[15:8];
      `SSR_RED_LOW_OFS:     rdata_d = red_q[7:0];
      `SSR_RED_HIGH_OFS:    rdata_d = red_q[15:8];
      `SSR_GREEN_LOW_OFS:   rdata_d = green_q[7:0];
      `SSR_GREEN_HIGH_OFS:  rdata_d = green_q[15:8];
      `SSR_BLUE_LOW_OFS:    rdata_d = blue_q[7:0];
      `SSR_BLUE_HIGH_OFS:   rdata_d = blue_q[15:8];
      `SSR_PROX_UPPER_OFS:  rdata_d = prox_q;
      `SSR_MISC_CONFIG_OFS: rdata_d = {read_clear_q, 7'h00};
      default:              rdata_d = 8'h00;
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule // ssr_status_result_regs

// ==== test/ssr_regs_monitor.sv ====
/* checker for the flag and result bank
   assumes it is bound to the bank and sees its ports only */
`timescale 1ns/100ps
module ssr_regs_monitor (
  input wire       sys_clk, sys_rst, reg_wr, reg_rd, read_clear_q, als_sat_evt, prox_int_evt,
  input wire       clear_int_evt, cal_done_evt, prox_sat_refl_evt, prox_sat_amb_evt,
  input wire [7:0] reg_addr, reg_wdata, flags_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // set wins over clear, so write and read clears are judged in quiet cycles only
  wire quiet = !(als_sat_evt | prox_int_evt | clear_int_evt | cal_done_evt | prox_sat_refl_evt
    | prox_sat_amb_evt);
  sequence s_wr; reg_wr && !reg_rd && reg_addr == 8'h93 && quiet; endsequence
  sequence s_rd; reg_rd && !reg_wr && reg_addr == 8'h93 && quiet; endsequence
  chk_asat_set: assert property (als_sat_evt |=> flags_q[7]) else $error("no bit 7");
  chk_refl_set: assert property (prox_sat_refl_evt |=> flags_q[6] && flags_q[1])
    else $error("no bits 6 1");
  chk_pint_set: assert property (prox_int_evt |=> flags_q[5]) else $error("no bit 5");
  chk_aint_set: assert property (clear_int_evt |=> flags_q[4]) else $error("no bit 4");
  chk_cint_set: assert property (cal_done_evt |=> flags_q[3]) else $error("no bit 3");
  chk_w1c_write: assert property (s_wr |=> flags_q == ($past(flags_q) & ~$past(reg_wdata)
    & {6'h3f, {2{!$past(reg_wdata[6])}}})) else $error("bad write clear");
  chk_rd_keep: assert property (s_rd ##0 !read_clear_q |=> $stable(flags_q))
    else $error("read changed flags");
  chk_rd_clear: assert property (s_rd ##0 read_clear_q |=> flags_q == 8'h00)
    else $error("read kept flags");
endmodule // ssr_regs_monitor
bind ssr_status_result_regs ssr_regs_monitor i_ssr_regs_monitor (.sys_clk, .sys_rst, .reg_wr,
  .reg_rd, .read_clear_q, .als_sat_evt, .prox_int_evt, .clear_int_evt, .cal_done_evt,
  .prox_sat_refl_evt, .prox_sat_amb_evt, .reg_addr, .reg_wdata, .flags_q);

// ==== test/ssr_host_model.sv ====
/* host side: one byte strobe per transfer
   assumes the bank takes a strobe at a rising edge */
`timescale 1ns/100ps
module ssr_host_model (
  input  wire       sys_clk,
  output reg  [7:0] reg_addr = 8'h00,
  output reg  [7:0] reg_wdata = 8'h00,
  output reg        reg_wr = 1'b0,
  output reg        reg_rd = 1'b0
);
  task xfer(input w, input [7:0] a, input [7:0] d); begin
    @(posedge sys_clk);
    #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge sys_clk);
    // released address and data lines show the inverse, never the old value
    #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  end endtask
endmodule // ssr_host_model

// ==== test/ssr_status_result_regs_test.sv ====
/* bench: bank against a behavioural model
   assumes the host model drives the register strobes */
`timescale 1ns/100ps
module ssr_status_result_regs_test;
  localparam [5:0] PART_ID = 6'h2a; // arbitrary value
  reg         sys_clk = 0, sys_rst = 1, cal_mode = 0, co = 0;
  reg  [8:0]  s = 9'h000;
  reg  [15:0] clear_meas = 0, red_meas = 0, green_meas = 0, blue_meas = 0, cal_result = 0;
  reg  [15:0] mc = 0, mr = 0, mg = 0, mb = 0;
  reg  [9:0]  prox_meas = 0;
  reg  [7:0]  mp = 0, fl = 0, a, w;
  wire        als_sat_evt, prox_int_evt, clear_int_evt, cal_done_evt, prox_sat_refl_evt;
  wire        prox_sat_amb_evt, als_done, cal_done, prox_done, reg_wr, reg_rd, read_clear_q;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata_q, flags_q;
  wire [87:0] img = {mp, mb, mg, mr, mc, fl, PART_ID, 2'b00};
  integer     num_errors = 0, checks_done = 0, seed = 32'hc7073a56, i;
  assign {als_sat_evt, prox_int_evt, clear_int_evt, cal_done_evt, prox_sat_refl_evt,
    prox_sat_amb_evt, als_done, cal_done, prox_done} = s;
  always #5 sys_clk = ~sys_clk;
  ssr_host_model i_ssr_host_model (.*);
  ssr_status_result_regs #(.PART_ID(PART_ID)) i_ssr_status_result_regs (.*);
  task check(input [7:0] seen, input [7:0] want); begin
    checks_done = checks_done + 1;
    if (seen !== want) begin
      num_errors = num_errors + 1;
      $display("ERROR %0t: saw %h want %h", $time, seen, want);
    end
  end endtask
  task report_and_stop; begin
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  end endtask
  task pulse(input [5:0] e, input [2:0] d); begin
    @(posedge sys_clk);
    #1 s = {e, d};
    @(posedge sys_clk);
    #1 s = 9'h000;
    fl = fl | {e[5], |e[1:0], e[4:2], 1'b0, e[1:0]};
    if (d[2]) {mr, mg, mb} = {red_meas, green_meas, blue_meas};
    if (d[2] && !cal_mode) mc = clear_meas;
    if (d[1] && cal_mode) mc = cal_result;
    if (d[0]) mp = prox_meas[9:2];
    check(flags_q, fl);
  end endtask
  task xrd(input [7:0] x); begin
    i_ssr_host_model.xfer(1'b0, x, 8'h00);
    w = (x > 8'h91 && x < 8'h9d) ? img[(x - 8'h92) * 8 +: 8] : {x == 8'hab && co, 7'h00};
    check(reg_rdata_q, w);
    if (x == 8'h93 && co) fl = 8'h00;
    check(flags_q, fl);
  end endtask
  task xwr(input [7:0] x, input [7:0] d); begin
    i_ssr_host_model.xfer(1'b1, x, d);
    if (x == 8'h93) fl = fl & ~d & {6'h3f, {2{!d[6]}}};
    if (x == 8'hab) co = d[7];
    check(flags_q, fl);
  end endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 sys_rst = 0;
    for (i = 0; i < 4; i = i + 1) begin
      xwr(8'h92 + i * 3, $random(seed));
      for (a = 8'h92; a != 8'h9d; a = a + 1) xrd(a);
      xrd(8'hab);
      xrd(8'ha0 + i);
      cal_mode = (i == 2);
      {clear_meas, red_meas, green_meas, blue_meas, cal_result, prox_meas} =
        {$random(seed), $random(seed), $random(seed)};
      pulse(6'h00, 3'b111);
    end
    for (i = 0; i < 6; i = i + 1) begin
      pulse(6'h01 << i, 3'b000);
      xrd(8'h93);
    end
    xwr(8'h93, 8'h40);
    xwr(8'h93, $random(seed));
    xwr(8'hab, 8'h80);
    pulse(6'h3f, 3'b000);
    xrd(8'h93);
    xrd(8'h93);
    xrd(8'hab);
    // event and write-one clear in one cycle: the event must survive
    fork
      i_ssr_host_model.xfer(1'b1, 8'h93, 8'hff);
      pulse(6'h20, 3'b000);
    join
    xrd(8'h93);
    // last captured results have not been read back yet
    for (a = 8'h94; a != 8'h9d; a = a + 1) xrd(a);
    report_and_stop;
  end
endmodule // ssr_status_result_regs_test
